// [logic/link_cfg_pkg.sv]
// Constants, types and helpers for the serial-link configuration bank.
// Assumes a single 20 MHz system clock shared by every user of the package.
package link_cfg_pkg;

  // System clock
  localparam int CLK_FREQ_HZ = 20_000_000;
  localparam int CLK_PERIOD_NS = 50;

  // Register offsets on the link
  localparam logic [15:0] OFS_STATION = 16'h0300;
  localparam logic [15:0] OFS_SPEED = 16'h0301;
  localparam logic [15:0] OFS_FORMAT = 16'h0302;
  localparam logic [15:0] OFS_FAULT_ACT = 16'h0303;
  localparam logic [15:0] OFS_WATCHDOG = 16'h0304;
  localparam logic [15:0] OFS_SRC_MASK = 16'h0306;
  localparam logic [15:0] OFS_DELAY = 16'h0307;
  localparam logic [15:0] OFS_IN_STATE = 16'h0407;

  // Values after reset
  localparam logic [7:0] RST_STATION = 8'h01;
  localparam logic [2:0] RST_SPEED = 3'h3;
  localparam logic [3:0] RST_FORMAT = 4'h0;
  localparam logic RST_FAULT_ACT = 1'b0;
  localparam logic [4:0] RST_WATCHDOG = 5'h00;
  localparam logic [5:0] RST_SRC_MASK = 6'h00;
  localparam logic [7:0] RST_DELAY = 8'h00;

  // Legal ranges
  localparam logic [7:0] STATION_MIN = 8'h01;
  localparam logic [7:0] STATION_MAX = 8'hfe;
  localparam logic [7:0] STATION_NODELAY = 8'hff;
  localparam logic [2:0] SPEED_MAX = 3'h5;
  localparam logic [3:0] FORMAT_MAX = 4'h8;
  localparam logic [3:0] FORMAT_RTU_FIRST = 4'h6;
  localparam logic [3:0] FORMAT_8BIT_FIRST = 4'h3;
  localparam logic [15:0] FAULT_ACT_MAX = 16'h0001;
  localparam logic [15:0] WATCHDOG_MAX_S = 16'h0014;
  localparam logic [15:0] INPUT_MAX = 16'h003f;
  localparam logic [15:0] DELAY_MAX = 16'h00ff;

  // Line speeds per code, and the bit-period divisor width
  localparam int BAUD_RATE [6] = '{4800, 9600, 19200, 38400, 57600, 115200};
  localparam int DIV_W = 13;

  // Time base: reply delay unit, second, RTU silence
  localparam int DELAY_UNIT_NS = 1_000_000;
  localparam int MS_TICK_CYCLES = DELAY_UNIT_NS / CLK_PERIOD_NS;
  localparam int MS_PER_SEC = 1000;
  localparam int RTU_GAP_MS = 10;
  localparam logic [3:0] RTU_GAP_TICKS = 4'(RTU_GAP_MS + 1);

  // Request sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DELAY = 2'b01,
    ST_REPLY = 2'b10
  } req_state_t;

  // Character format as the framer needs it
  typedef struct packed {
    logic rtu;
    logic data8;
    logic par_en;
    logic par_odd;
    logic stop2;
  } char_fmt_t;

  // Bit-period divisor limit for a speed code
  function automatic logic [DIV_W-1:0] baud_limit(input logic [2:0] code);
    baud_limit = DIV_W'(CLK_FREQ_HZ / BAUD_RATE[code] - 1);
  endfunction

endpackage

// [logic/tick_if.sv]
// Carrier between a tick owner and a tick_divider instance.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/10ps
interface tick_if #(parameter int W = 13) ();
  logic en;
  logic clr;
  logic [W-1:0] limit;
  logic tick;
  modport owner (output en, output clr, output limit, input tick);
  modport counter (input en, input clr, input limit, output tick);
endinterface

// [logic/tick_divider.sv]
// Enable-driven divider: one-cycle tick every limit+1 enables.
// Assumes synchronous active-high reset and a steady enable source.
`timescale 1ns/10ps
module tick_divider #(
  parameter int W = 13
) (
  input wire logic clk_i,
  input wire logic rst_i,
  tick_if.counter div
);

  if (W < 1 || W > 24) begin : g_chk
    $error("tick_divider: width out of range");
  end

  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } div_state_t;

  div_state_t s_q;
  div_state_t s_d;

  // Count enables, wrap at the limit
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (div.clr) begin
      s_d.cnt = '0;
    end else if (div.en) begin
      if (s_q.cnt >= div.limit) begin
        s_d.cnt = '0;
        s_d.tick = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + W'(1);
      end
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign div.tick = s_q.tick;

endmodule // tick_divider

// [logic/serial_link_config.sv]
// Serial-link configuration bank of a drive acting as a bus slave.
// Assumes a framer outside decodes frames into register requests.
//
// Behaviour
// - Station address holds 1 to 254, resets to 1, unique per line.
// - Speed code 0..5 picks 4800 to 115200 bit/s, resets to 3.
// - Format codes 0..5 pick ASCII 7N2,7E1,7O1,8N2,8E1,8O1; reset 0.
// - Format codes 6..8 pick RTU 8N2, 8E1, 8O1.
// - Format gives data bits, parity and stop bits; host matches it.
// - Link faults are reported; action 1 also requests a stop.
// - Watchdog spans 0 to 20 s, resets to 0; 0 disables it.
// - Nonzero watchdog flags an error if no valid traffic in time.
// - Six-bit source mask: clear takes connector input, set takes link.
// - Bit 0 is input 1 up to bit 5 input 6, each independent.
// - Reading the input-state word returns the six input states.
// - Writing the input-state word drives the link-sourced inputs.
// - Each reply waits the programmed delay, 0 to 255, reset 0.
// - Requests to address 255 get no reply delay.
// - Only requests with our own address or address 255 are acted on.
// - One physical interface at a time, chosen by an input.
// - RTU frames are bounded by line silence above 10 ms.
// - ASCII bytes travel as two hex characters 30h-39h, 41h-46h.
`timescale 1ns/10ps
module serial_link_config
  import link_cfg_pkg::*;
#(
  parameter int MS_CYCLES = MS_TICK_CYCLES
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic REQ_VALID_I,
  input wire logic [7:0] REQ_STATION_I,
  input wire logic REQ_WRITE_I,
  input wire logic [15:0] REQ_ADDR_I,
  input wire logic [15:0] REQ_WDATA_I,
  output logic REQ_READY_O,
  output logic REQ_ACCEPT_O,
  output logic RSP_VALID_O,
  output logic [15:0] RSP_DATA_O,
  output logic RSP_ERR_O,
  input wire logic LINK_IDLE_I,
  input wire logic FRAME_VALID_I,
  input wire logic FRAME_FAULT_I,
  input wire logic FAULT_CLEAR_I,
  output logic COMM_FAULT_O,
  output logic FAULT_STOP_O,
  input wire logic IF_SELECT_I,
  input wire logic RS232_RX_I,
  input wire logic RS485_RX_I,
  input wire logic TX_I,
  input wire logic TX_EN_I,
  output logic RX_O,
  output logic RS232_TX_O,
  output logic RS485_TX_O,
  output logic RS485_DRIVE_O,
  output logic BAUD_TICK_O,
  output logic [4:0] CHAR_FMT_O,
  output logic RTU_GAP_O,
  output logic [7:0] STATION_O,
  output logic [15:0] STATION_ASCII_O,
  input wire logic [5:0] EXT_INPUTS_I,
  output logic [5:0] LOGIC_INPUTS_O
);

  localparam int MS_W = $clog2(MS_CYCLES);
  localparam int SEC_W = $clog2(MS_PER_SEC);

  if (MS_CYCLES < 2 || MS_CYCLES > (1 << 20)) begin : g_chk
    $error("serial_link_config: MS_CYCLES out of range");
  end

  typedef struct packed {
    req_state_t st;
    logic [7:0] station;
    logic [2:0] speed;
    logic [3:0] fmt;
    logic action;
    logic [4:0] wdog;
    logic [5:0] mask;
    logic [5:0] link_in;
    logic [7:0] delay;
    logic [2:0] act_speed;
    logic [3:0] act_fmt;
    logic fault;
    logic [4:0] wd_cnt;
    logic [3:0] gap_cnt;
    logic [7:0] dly_cnt;
    logic [15:0] rsp_data;
    logic rsp_err;
    logic acc;
    logic rx;
    logic tx232;
    logic tx485;
    logic drive485;
    logic [5:0] logic_in;
  } cfg_state_t;

  cfg_state_t s_q;
  cfg_state_t s_d;

  tick_if #(.W(DIV_W)) baud_if ();
  tick_if #(.W(MS_W)) ms_if ();
  tick_if #(.W(SEC_W)) sec_if ();

  // Nibble to hex character
  function automatic logic [7:0] hex_char(input logic [3:0] nib);
    hex_char = (nib < 4'ha) ? 8'h30 + {4'h0, nib} : 8'h37 + {4'h0, nib};
  endfunction

  // Character layout from a format code
  function automatic char_fmt_t fmt_decode(input logic [3:0] code);
    logic [3:0] par;
    par = (code >= FORMAT_RTU_FIRST) ? code - FORMAT_RTU_FIRST : code % 4'h3;
    fmt_decode.rtu = code >= FORMAT_RTU_FIRST;
    fmt_decode.data8 = code >= FORMAT_8BIT_FIRST;
    fmt_decode.par_en = par != 4'h0;
    fmt_decode.par_odd = par == 4'h2;
    fmt_decode.stop2 = par == 4'h0;
  endfunction

  logic take;
  logic addressed;
  logic wd_expire;
  char_fmt_t act;

  // Request for us, taken only in idle
  assign addressed = REQ_STATION_I == s_q.station || REQ_STATION_I == STATION_NODELAY;
  assign take = REQ_VALID_I && addressed && s_q.st == ST_IDLE;
  assign act = fmt_decode(s_q.act_fmt);
  assign wd_expire = s_q.wdog != 5'h00 && sec_if.tick && s_q.wd_cnt == s_q.wdog - 5'h01;

  // Time bases: bit period, millisecond, second
  assign baud_if.en = 1'b1;
  assign baud_if.clr = 1'b0;
  assign baud_if.limit = baud_limit(s_q.act_speed);
  assign ms_if.en = 1'b1;
  assign ms_if.clr = take;
  assign ms_if.limit = MS_W'(MS_CYCLES - 1);
  assign sec_if.en = ms_if.tick;
  assign sec_if.clr = FRAME_VALID_I;
  assign sec_if.limit = SEC_W'(MS_PER_SEC - 1);

  tick_divider #(.W(DIV_W)) u_baud (.clk_i(CLK_SYS_I), .rst_i(RST_I), .div(baud_if.counter));
  tick_divider #(.W(MS_W)) u_ms (.clk_i(CLK_SYS_I), .rst_i(RST_I), .div(ms_if.counter));
  tick_divider #(.W(SEC_W)) u_sec (.clk_i(CLK_SYS_I), .rst_i(RST_I), .div(sec_if.counter));

  // Next-state logic
  always_comb begin
    logic [15:0] rdata;
    logic hit;
    logic ok;
    rdata = 16'h0000;
    hit = 1'b1;
    ok = 1'b1;
    s_d = s_q;
    s_d.acc = 1'b0;
    // One interface live at a time
    s_d.rx = IF_SELECT_I ? RS485_RX_I : RS232_RX_I;
    s_d.tx232 = IF_SELECT_I ? 1'b1 : TX_I;
    s_d.tx485 = IF_SELECT_I ? TX_I : 1'b1;
    s_d.drive485 = IF_SELECT_I & TX_EN_I;
    // Line settings follow the registers only between frames
    if (LINK_IDLE_I) begin
      s_d.act_speed = s_q.speed;
      s_d.act_fmt = s_q.fmt;
    end
    // Silence timer for RTU frame bounds
    if (!s_q.rx) begin
      s_d.gap_cnt = 4'h0;
    end else if (ms_if.tick && s_q.gap_cnt != RTU_GAP_TICKS) begin
      s_d.gap_cnt = s_q.gap_cnt + 4'h1;
    end
    // Watchdog seconds since the last valid frame
    if (FRAME_VALID_I || s_q.wdog == 5'h00 || wd_expire) begin
      s_d.wd_cnt = 5'h00;
    end else if (sec_if.tick) begin
      s_d.wd_cnt = s_q.wd_cnt + 5'h01;
    end
    // Fault flag: a new fault wins over a clear
    if (FAULT_CLEAR_I) begin
      s_d.fault = 1'b0;
    end
    if (FRAME_FAULT_I || wd_expire) begin
      s_d.fault = 1'b1;
    end
    // Per-input source routing
    s_d.logic_in = (s_q.mask & s_q.link_in) | (~s_q.mask & EXT_INPUTS_I);
    // Register read data
    unique case (REQ_ADDR_I)
      OFS_STATION: rdata = {8'h00, s_q.station};
      OFS_SPEED: rdata = {13'h0000, s_q.speed};
      OFS_FORMAT: rdata = {12'h000, s_q.fmt};
      OFS_FAULT_ACT: rdata = {15'h0000, s_q.action};
      OFS_WATCHDOG: rdata = {11'h000, s_q.wdog};
      OFS_SRC_MASK: rdata = {10'h000, s_q.mask};
      OFS_DELAY: rdata = {8'h00, s_q.delay};
      OFS_IN_STATE: rdata = {10'h000, s_q.logic_in};
      default: hit = 1'b0;
    endcase
    // Range check of write data
    unique case (REQ_ADDR_I)
      OFS_STATION: ok = REQ_WDATA_I >= 16'(STATION_MIN) && REQ_WDATA_I <= 16'(STATION_MAX);
      OFS_SPEED: ok = REQ_WDATA_I <= 16'(SPEED_MAX);
      OFS_FORMAT: ok = REQ_WDATA_I <= 16'(FORMAT_MAX);
      OFS_FAULT_ACT: ok = REQ_WDATA_I <= FAULT_ACT_MAX;
      OFS_WATCHDOG: ok = REQ_WDATA_I <= WATCHDOG_MAX_S;
      OFS_SRC_MASK: ok = REQ_WDATA_I <= INPUT_MAX;
      OFS_DELAY: ok = REQ_WDATA_I <= DELAY_MAX;
      OFS_IN_STATE: ok = REQ_WDATA_I <= INPUT_MAX;
      default: ok = 1'b0;
    endcase
    // Request sequencer
    unique case (s_q.st)
      ST_IDLE: begin
        if (take) begin
          s_d.acc = 1'b1;
          s_d.rsp_err = !hit || (REQ_WRITE_I && !ok);
          s_d.rsp_data = (REQ_WRITE_I && ok) ? REQ_WDATA_I : rdata;
          if (REQ_WRITE_I && ok) begin
            unique case (REQ_ADDR_I)
              OFS_STATION: s_d.station = REQ_WDATA_I[7:0];
              OFS_SPEED: s_d.speed = REQ_WDATA_I[2:0];
              OFS_FORMAT: s_d.fmt = REQ_WDATA_I[3:0];
              OFS_FAULT_ACT: s_d.action = REQ_WDATA_I[0];
              OFS_WATCHDOG: s_d.wdog = REQ_WDATA_I[4:0];
              OFS_SRC_MASK: s_d.mask = REQ_WDATA_I[5:0];
              OFS_DELAY: s_d.delay = REQ_WDATA_I[7:0];
              OFS_IN_STATE: s_d.link_in = REQ_WDATA_I[5:0];
              default: s_d.station = s_q.station;
            endcase
          end
          if (REQ_STATION_I == STATION_NODELAY || s_q.delay == 8'h00) begin
            s_d.st = ST_REPLY;
          end else begin
            s_d.st = ST_DELAY;
            s_d.dly_cnt = s_q.delay;
          end
        end
      end
      ST_DELAY: begin
        if (ms_if.tick) begin
          s_d.dly_cnt = s_q.dly_cnt - 8'h01;
          if (s_q.dly_cnt == 8'h01) begin
            s_d.st = ST_REPLY;
          end
        end
      end
      ST_REPLY: s_d.st = ST_IDLE;
      default: s_d.st = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.station <= RST_STATION;
      s_q.speed <= RST_SPEED;
      s_q.act_speed <= RST_SPEED;
      s_q.fmt <= RST_FORMAT;
      s_q.act_fmt <= RST_FORMAT;
      s_q.action <= RST_FAULT_ACT;
      s_q.wdog <= RST_WATCHDOG;
      s_q.mask <= RST_SRC_MASK;
      s_q.delay <= RST_DELAY;
      s_q.rx <= 1'b1;
      s_q.tx232 <= 1'b1;
      s_q.tx485 <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign REQ_READY_O = s_q.st == ST_IDLE;
  assign REQ_ACCEPT_O = s_q.acc;
  assign RSP_VALID_O = s_q.st == ST_REPLY;
  assign RSP_DATA_O = s_q.rsp_data;
  assign RSP_ERR_O = s_q.rsp_err;
  assign COMM_FAULT_O = s_q.fault;
  assign FAULT_STOP_O = s_q.fault & s_q.action;
  assign RX_O = s_q.rx;
  assign RS232_TX_O = s_q.tx232;
  assign RS485_TX_O = s_q.tx485;
  assign RS485_DRIVE_O = s_q.drive485;
  assign BAUD_TICK_O = baud_if.tick;
  assign CHAR_FMT_O = act;
  assign RTU_GAP_O = act.rtu && s_q.gap_cnt == RTU_GAP_TICKS;
  assign STATION_O = s_q.station;
  assign STATION_ASCII_O = {hex_char(s_q.station[7:4]), hex_char(s_q.station[3:0])};
  assign LOGIC_INPUTS_O = s_q.logic_in;

  // Checks
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);

  property p_station_range;
    s_q.station >= STATION_MIN && s_q.station <= STATION_MAX;
  endproperty
  a_station_range: assert property (p_station_range) else $error("station out of range");

  property p_reject_bad;
    take && REQ_WRITE_I && REQ_ADDR_I == OFS_SPEED && REQ_WDATA_I > 16'(SPEED_MAX)
      |=> $stable(s_q.speed) && RSP_ERR_O;
  endproperty
  a_reject_bad: assert property (p_reject_bad) else $error("bad speed write stored");

  property p_fmt_between;
    !LINK_IDLE_I |=> $stable(CHAR_FMT_O) && $stable(s_q.act_speed);
  endproperty
  a_fmt_between: assert property (p_fmt_between) else $error("format changed mid-frame");

  property p_fault_set;
    FRAME_FAULT_I |=> COMM_FAULT_O && (FAULT_STOP_O == s_q.action);
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault not reported");

  property p_wd_off;
    s_q.wdog == 5'h00 && !FRAME_FAULT_I && !COMM_FAULT_O |=> !COMM_FAULT_O;
  endproperty
  a_wd_off: assert property (p_wd_off) else $error("disabled watchdog fired");

  property p_route;
    ##1 LOGIC_INPUTS_O == (($past(s_q.mask) & $past(s_q.link_in)) | (~$past(s_q.mask) & $past(EXT_INPUTS_I)));
  endproperty
  a_route: assert property (p_route) else $error("input routing wrong");

  property p_no_delay;
    take && REQ_STATION_I == STATION_NODELAY |=> RSP_VALID_O ##1 !RSP_VALID_O;
  endproperty
  a_no_delay: assert property (p_no_delay) else $error("reply delayed for 255");

  property p_delay_held;
    take && REQ_STATION_I != STATION_NODELAY && s_q.delay != 8'h00 |=> !RSP_VALID_O [*2];
  endproperty
  a_delay_held: assert property (p_delay_held) else $error("reply not delayed");

  property p_foreign;
    REQ_VALID_I && !addressed |=> !REQ_ACCEPT_O;
  endproperty
  a_foreign: assert property (p_foreign) else $error("foreign request taken");

  property p_one_port;
    IF_SELECT_I |=> RS232_TX_O;
  endproperty
  a_one_port: assert property (p_one_port) else $error("idle port driven");

  c_write: cover property (take && REQ_WRITE_I ##1 !RSP_ERR_O);
  c_delayed: cover property (s_q.st == ST_DELAY ##1 RSP_VALID_O);
  c_watchdog: cover property (wd_expire);
  c_gap: cover property (RTU_GAP_O);

endmodule // serial_link_config

// [test/link_host_model.sv]
// Host-side request driver standing in for the frame decoder.
// Assumes requests are sampled on the rising edge of clk_i.
`timescale 1ns/10ps
module link_host_model (
  input wire logic clk_i,
  input wire logic ready_i,
  input wire logic rsp_valid_i,
  output logic valid_o,
  output logic [7:0] station_o,
  output logic write_o,
  output logic [15:0] addr_o,
  output logic [15:0] wdata_o
);
  // Quiet request lines at time zero
  initial begin
    valid_o = 1'b0;
    station_o = 8'h00;
    write_o = 1'b0;
    addr_o = 16'h0000;
    wdata_o = 16'h0000;
  end

  // One request: hold until taken, release, wait a bounded time for the reply
  task automatic xfer(input logic [7:0] st, input logic wr, input logic [15:0] a,
      input logic [15:0] d, input int lim, output logic got);
    int n;
    @(posedge clk_i);
    #1;
    valid_o = 1'b1;
    station_o = st;
    write_o = wr;
    addr_o = a;
    wdata_o = d;
    n = 0;
    while (ready_i !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    @(posedge clk_i);
    #1;
    // Released lines show the inverse, never the stale value
    valid_o = 1'b0;
    station_o = ~st;
    write_o = ~wr;
    addr_o = ~a;
    wdata_o = ~d;
    got = 1'b0;
    n = 0;
    while (got == 1'b0 && n < lim) begin
      if (rsp_valid_i === 1'b1) got = 1'b1;
      else begin
        @(posedge clk_i);
        #1;
        n++;
      end
    end
  endtask
endmodule // link_host_model

// [test/serial_link_config_tb.sv]
// Self-checking bench for the serial-link configuration bank.
// Assumes link_host_model drives the request port; time unit shortened.
`timescale 1ns/10ps
module serial_link_config_tb;
  import link_cfg_pkg::*;
  localparam int MS = 4;
  localparam logic [15:0] ofs [7] = '{OFS_STATION, OFS_SPEED, OFS_FORMAT, OFS_FAULT_ACT,
    OFS_WATCHDOG, OFS_SRC_MASK, OFS_DELAY};
  localparam logic [15:0] rstv [7] = '{16'h0001, 16'h0003, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  localparam logic [15:0] maxv [7] = '{16'h00fe, 16'h0005, 16'h0008, 16'h0001, 16'h0014, 16'h003f, 16'h00ff};
  localparam logic [15:0] badv [7] = '{16'h00ff, 16'h0006, 16'h0009, 16'h0002, 16'h0015, 16'h0040, 16'h0100};
  typedef struct {logic [15:0] d; logic e; logic cd; int lat;} note_t;
  logic clk, rst, idle, fvalid, ffault, fclr, sel, rx232, rx485, tx, txen;
  logic valid, wrt, ready, accept, rvalid, rerr, got, fault, fstop, rxo, tx232, tx485, drv, btick, gap;
  logic [4:0] fmt;
  logic [5:0] ext, lin;
  logic [7:0] stn, own, dly, st_o;
  logic [15:0] addr, wdata, rdata, st_asc;
  logic [31:0] seed;
  int err_total, cmp_count, cyc, t_acc;
  note_t notes[$];

  serial_link_config #(.MS_CYCLES(MS)) dut (.CLK_SYS_I(clk), .RST_I(rst), .REQ_VALID_I(valid),
    .REQ_STATION_I(stn), .REQ_WRITE_I(wrt), .REQ_ADDR_I(addr), .REQ_WDATA_I(wdata), .REQ_READY_O(ready),
    .REQ_ACCEPT_O(accept), .RSP_VALID_O(rvalid), .RSP_DATA_O(rdata), .RSP_ERR_O(rerr), .LINK_IDLE_I(idle),
    .FRAME_VALID_I(fvalid), .FRAME_FAULT_I(ffault), .FAULT_CLEAR_I(fclr), .COMM_FAULT_O(fault),
    .FAULT_STOP_O(fstop), .IF_SELECT_I(sel), .RS232_RX_I(rx232), .RS485_RX_I(rx485), .TX_I(tx),
    .TX_EN_I(txen), .RX_O(rxo), .RS232_TX_O(tx232), .RS485_TX_O(tx485), .RS485_DRIVE_O(drv),
    .BAUD_TICK_O(btick), .CHAR_FMT_O(fmt), .RTU_GAP_O(gap), .STATION_O(st_o), .STATION_ASCII_O(st_asc),
    .EXT_INPUTS_I(ext), .LOGIC_INPUTS_O(lin));

  link_host_model host (.clk_i(clk), .ready_i(ready), .rsp_valid_i(rvalid), .valid_o(valid),
    .station_o(stn), .write_o(wrt), .addr_o(addr), .wdata_o(wdata));

  task automatic close_out();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic ck(input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (e !== g) begin
      err_total++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Active format bits {rtu,data8,par_en,par_odd,stop2} for a code
  function automatic logic [4:0] fexp(input int c);
    return {c >= 6, c >= 3, c % 3 != 0, c % 3 == 2, c % 3 == 0};
  endfunction

  // Note the expected reply, then let the host issue the request
  task automatic req(input logic [7:0] st, input logic w, input logic [15:0] a, input logic [15:0] d,
      input logic [15:0] ed, input logic ee, input logic cd);
    note_t n;
    n.d = ed;
    n.e = ee;
    n.cd = cd;
    // Delayed replies land one cycle after the last millisecond tick
    n.lat = (st == 8'hff || dly == 8'h00) ? 0 : int'(dly) * MS + 1;
    notes.push_back(n);
    host.xfer(st, w, a, d, n.lat + 20, got);
    ck(1, got);
  endtask

  // Writes go to the no-delay address so their reply time is fixed
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic ok);
    req(8'hff, 1'b1, a, d, d, ~ok, ok);
    if (ok && a == OFS_STATION) own = d[7:0];
    if (ok && a == OFS_DELAY) dly = d[7:0];
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    req(own, 1'b0, a, 16'h0000, e, 1'b0, 1'b1);
  endtask

  // Cycles between the second and third baud ticks
  task automatic period(output int p);
    int k;
    k = 0;
    p = 0;
    while (k < 3 && p < 20000) begin
      @(negedge clk);
      if (k == 2) p++;
      if (btick === 1'b1) k++;
    end
  endtask

  // Reply watcher: every reply takes the oldest note
  always @(negedge clk) begin
    note_t n;
    if (accept === 1'b1) t_acc = cyc;
    if (rvalid === 1'b1) begin
      if (notes.size() == 0) ck(32'h0, 32'h1);
      else begin
        n = notes.pop_front();
        ck(n.e, rerr);
        if (n.cd) ck(n.d, rdata);
        ck(n.lat, cyc - t_acc);
      end
    end
  end

  // Cycle count and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_total++;
      close_out();
    end
  end

  // Clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Main sequence
  initial begin
    logic [31:0] r;
    logic [5:0] m, s, rt;
    int p;
    rst = 1'b1;
    {idle, fvalid, ffault, fclr, sel, rx232, rx485, tx, txen} = 9'b100001110;
    ext = 6'h00;
    seed = 32'd68;
    err_total = 0;
    cmp_count = 0;
    cyc = 0;
    t_acc = 0;
    own = 8'h01;
    dly = 8'h00;
    cyc_n(12);
    rst = 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd(ofs[i], rstv[i]);
      wr(ofs[i], maxv[i], 1'b1);
      rd(ofs[i], maxv[i]);
      wr(ofs[i], badv[i], 1'b0);
      rd(ofs[i], maxv[i]);
      wr(ofs[i], rstv[i], 1'b1);
    end
    wr(OFS_STATION, 16'h0000, 1'b0);
    req(own, 1'b0, 16'h0305, 16'h0000, 16'h0000, 1'b1, 1'b0);
    wr(OFS_DELAY, 16'h0003, 1'b1);
    rd(OFS_DELAY, 16'h0003);
    req(8'hff, 1'b0, OFS_DELAY, 16'h0000, 16'h0003, 1'b0, 1'b1);
    host.xfer(8'h22, 1'b0, OFS_STATION, 16'h0000, 30, got);
    ck(0, got);
    wr(OFS_DELAY, 16'h0000, 1'b1);
    for (int c = 0; c < 9; c++) begin
      wr(OFS_FORMAT, 16'(c), 1'b1);
      cyc_n(2);
      ck(fexp(c), fmt);
    end
    idle = 1'b0;
    wr(OFS_FORMAT, 16'h0006, 1'b1);
    cyc_n(2);
    ck(fexp(8), fmt);
    idle = 1'b1;
    cyc_n(2);
    ck(fexp(6), fmt);
    rx232 = 1'b0;
    cyc_n(3);
    rx232 = 1'b1;
    cyc_n(9 * MS);
    ck(0, gap);
    cyc_n(4 * MS);
    ck(1, gap);
    for (int c = 0; c < 6; c++) begin
      wr(OFS_SPEED, 16'(c), 1'b1);
      period(p);
      ck(CLK_FREQ_HZ / BAUD_RATE[c], p);
    end
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      {sel, rx232, rx485, tx, txen} = r[4:0];
      cyc_n(2);
      ck(sel ? rx485 : rx232, rxo);
      ck(sel ? 1'b1 : tx, tx232);
      ck(sel ? tx : 1'b1, tx485);
      ck(sel & txen, drv);
    end
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      ext = r[5:0];
      m = r[13:8];
      s = r[21:16];
      rt = (m & s) | (~m & ext);
      wr(OFS_SRC_MASK, {10'h000, m}, 1'b1);
      wr(OFS_IN_STATE, {10'h000, s}, 1'b1);
      cyc_n(2);
      ck(rt, lin);
      rd(OFS_IN_STATE, {10'h000, rt});
    end
    wr(OFS_IN_STATE, 16'h0040, 1'b0);
    for (int a = 0; a < 2; a++) begin
      wr(OFS_FAULT_ACT, 16'(a), 1'b1);
      ffault = 1'b1;
      cyc_n(1);
      ffault = 1'b0;
      cyc_n(2);
      ck(1, fault);
      ck(a, fstop);
      fclr = 1'b1;
      cyc_n(1);
      fclr = 1'b0;
      cyc_n(2);
      ck(0, fault);
    end
    // Hold a valid frame across the write so no stale second tick expires it
    fvalid = 1'b1;
    wr(OFS_WATCHDOG, 16'h0001, 1'b1);
    for (int i = 0; i < 2; i++) begin
      fvalid = 1'b1;
      cyc_n(1);
      fvalid = 1'b0;
      cyc_n(1000 * MS - 20);
      ck(0, fault);
    end
    cyc_n(40);
    ck(1, fault);
    wr(OFS_WATCHDOG, 16'h0000, 1'b1);
    fclr = 1'b1;
    cyc_n(1);
    fclr = 1'b0;
    cyc_n(1000 * MS + 100);
    ck(0, fault);
    wr(OFS_STATION, 16'h003c, 1'b1);
    cyc_n(1);
    ck(8'h3c, st_o);
    ck(16'h3343, st_asc);
    rd(OFS_STATION, 16'h003c);
    close_out();
  end
endmodule // serial_link_config_tb
